/* bench/pad_model.sv */
`timescale 1ns/1ps
module pad_model (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pad_pullup,
    input  wire logic [7:0] pad_pulldown,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_oe,
    output logic      [7:0] pin_in
);
    logic [7:0] float_r;
    // Unterminated, undriven pins wander every cycle
    always @(posedge pclk) begin
        float_r <= (float_r === 8'h55) ? 8'haa : 8'h55;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_oe[i])
                pin_in[i] = ext_val[i];
            else if (pad_pullup[i])
                pin_in[i] = 1'b1;
            else if (pad_pulldown[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = float_r[i];
        end
    end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import gpio_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [7:0]  ext_val = 8'ha5;
    logic [7:0]  ext_oe  = 8'hff;
    logic [15:0] p_o     = 16'h0;
    logic [15:0] p_oe    = 16'h0;
    logic [15:0] cl_in   = 16'h0;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, irq_sum, rerr;
    logic [7:0]  pin_in, pin_out, pin_oe, pup, pdn, ana, wen, whi, irq_pin;
    logic [23:0] pad_drive;
    logic [15:0] cl_out, p_in, p_vld;
    logic [2:0]  s;
    logic [3:0]  sense_exp [5] = '{4'h1, 4'h4, 4'h5, 4'hd, 4'h7};
    int          error_cnt = 0;
    int          checked   = 0;

    always #5 pclk = ~pclk;

    gpio_port i_gpio_port (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pad_pullup(pup),
        .pad_pulldown(pdn), .pad_analog_en(ana), .wake_en(wen),
        .wake_high(whi), .pad_drive(pad_drive), .periph_o(p_o),
        .periph_oe(p_oe), .claim_in(cl_in), .claim_out(cl_out),
        .periph_in(p_in), .periph_in_vld(p_vld), .irq_sum(irq_sum),
        .irq_pin(irq_pin));
    pad_model i_pad_model (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pad_pullup(pup), .pad_pulldown(pdn), .ext_val(ext_val),
        .ext_oe(ext_oe), .pin_in(pin_in));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Pin read; the word above bit 7 carries nothing
    task rdp(input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, {DATA_WIN, m, 2'b00}, 32'h0);
        chk({24'h0, rdat[7:0]}, {24'h0, e});
    endtask
    task summarize;
        $display("checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial begin
        tick(6);
        presetn <= 1'b1;
        rd(OFS_DIR, {16'h0, RST_DIR});
        rd(OFS_PINSEL, {24'h0, RST_PINSEL});
        apb(1'b0, 12'h42c, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        rdp(8'h0f, 8'h05);
        rdp(8'hf0, 8'ha0);
        // ----------------------------------------------------------------
        // Every sense type on pin 4, inputs still while type changes
        // ----------------------------------------------------------------
        for (int k = 0; k < 5; k++) begin
            s = 3'(k);
            ext_val <= 8'h00;
            tick(6);
            wr(OFS_INTTYPE, {17'h0, s, 12'h0});
            wr(OFS_RAW, 32'hff);
            rd(OFS_RAW, {27'h0, sense_exp[k][3], 4'h0});
            ext_val <= 8'h10;
            tick(6);
            rd(OFS_RAW, {27'h0, sense_exp[k][2], 4'h0});
            wr(OFS_RAW, 32'hff);
            rd(OFS_RAW, {27'h0, sense_exp[k][1], 4'h0});
            ext_val <= 8'h00;
            tick(6);
            rd(OFS_RAW, {27'h0, sense_exp[k][0], 4'h0});
        end
        wr(OFS_INTEN, 32'h10);
        rd(OFS_MASKED, 32'h10);
        chk({31'h0, irq_sum}, 32'h1);
        wr(OFS_INTEN, 32'h0);
        tick(2);
        chk({31'h0, irq_sum}, 32'h0);
        wr(OFS_INTTYPE, {7'h0, 1'b1, 9'h0, SENSE_HIGH, 12'h0});
        rd(OFS_INTTYPE, {7'h0, 1'b1, 9'h0, SENSE_HIGH, 12'h0});
        wr(OFS_INTEN, 32'h10);
        ext_val <= 8'h10;
        tick(6);
        chk({24'h0, irq_pin}, 32'h10);
        chk({31'h0, irq_sum}, 32'h0);
        // ----------------------------------------------------------------
        // Every drive and pad code on input pin 5
        // ----------------------------------------------------------------
        for (int k = 0; k < 7; k++) begin
            s = 3'(k);
            wr(OFS_DRIVE, {14'h0, s, 15'h0});
            wr(OFS_PAD, {14'h0, s, 15'h0});
            rd(OFS_DRIVE, {14'h0, s, 15'h0});
            rd(OFS_PAD, {14'h0, s, 15'h0});
            chk({29'h0, pad_drive[17:15]}, {29'h0, s});
            chk({27'h0, pup[5], pdn[5], ana[5], wen[5], whi[5]},
                {27'h0, k == 1, k == 2, k == 4, k >= 5, k == 5});
        end
        // ----------------------------------------------------------------
        // Protected pin 0, outputs read back, masked writes
        // ----------------------------------------------------------------
        wr(OFS_DIR, 32'h0101);
        rd(OFS_DIR, 32'h0100);
        wr(OFS_LOCK, LOCK_KEY);
        wr(OFS_COMMIT, 32'h01);
        wr(OFS_DIR, 32'h0101);
        rd(OFS_DIR, 32'h0101);
        ext_val <= 8'h00;
        ext_oe <= 8'hee;
        wr({DATA_WIN, 8'h11, 2'b00}, 32'hff);
        tick(4);
        chk({24'h0, pin_oe}, 32'h11);
        rdp(8'hff, 8'h11);
        wr({DATA_WIN, 8'h01, 2'b00}, 32'h00);
        tick(4);
        rdp(8'hff, 8'h10);
        // ----------------------------------------------------------------
        // Function 3 on pin 4, then claimed by a lower port
        // ----------------------------------------------------------------
        wr(OFS_AFSEL, 32'h00030000);
        wr(OFS_DIR, {22'h0, dir_peripheral_ctrl, 8'h01});
        p_o <= 16'h0008;
        p_oe <= 16'h0008;
        tick(3);
        chk({16'h0, pin_oe & 8'h10, pin_out & 8'h10}, 32'h1010);
        chk({16'h0, cl_out}, 32'h0008);
        tick(2);
        chk({p_vld, p_in}, 32'h00080008);
        p_o <= 16'h0;
        tick(3);
        chk({24'h0, pin_out & 8'h10}, 32'h0);
        cl_in <= 16'h0008;
        tick(3);
        chk({24'h0, pin_oe}, 32'h01);
        chk({p_vld, p_in}, 32'h0);
        summarize();
    end
endmodule

/* verilog/gpio_pkg.sv */
package gpio_pkg;
    localparam int          NPIN      = 8;
    localparam int          NFUNC     = 16;
    localparam int          SELW      = 4;
    localparam int          SENSE_W   = 3;
    localparam int          PADW      = 3;
    localparam int          DRVW      = 3;
    localparam int          DIRW      = 2;
    localparam int          AW        = 12;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_DIR     = 12'h400;
    localparam logic [11:0] OFS_INTTYPE = 12'h404;
    localparam logic [11:0] OFS_INTEN   = 12'h408;
    localparam logic [11:0] OFS_RAW     = 12'h40c;
    localparam logic [11:0] OFS_MASKED  = 12'h410;
    localparam logic [11:0] OFS_DRIVE   = 12'h414;
    localparam logic [11:0] OFS_PAD     = 12'h418;
    localparam logic [11:0] OFS_AFSEL   = 12'h41c;
    localparam logic [11:0] OFS_LOCK    = 12'h420;
    localparam logic [11:0] OFS_COMMIT  = 12'h424;
    localparam logic [11:0] OFS_PINSEL  = 12'h428;
    localparam logic [1:0]  DATA_WIN    = 2'h0;
    localparam int          DISC_BIT    = 24;
    // Unlock key, value arbitrary
    localparam logic [31:0] LOCK_KEY    = 32'h600dcafe;
    // ----------------------------------------------------------------
    // Field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  DIR_IN              = 2'h0;
    localparam logic [1:0]  DIR_OUT             = 2'h1;
    localparam logic [1:0]  dir_peripheral_ctrl = 2'h2;
    localparam logic [2:0]  SENSE_FALL  = 3'h0;
    localparam logic [2:0]  SENSE_RISE  = 3'h1;
    localparam logic [2:0]  SENSE_BOTH  = 3'h2;
    localparam logic [2:0]  SENSE_LOW   = 3'h3;
    localparam logic [2:0]  SENSE_HIGH  = 3'h4;
    localparam logic [2:0]  drive_2ma      = 3'h0;
    localparam logic [2:0]  drive_4ma      = 3'h1;
    localparam logic [2:0]  drive_8ma      = 3'h2;
    localparam logic [2:0]  drive_8ma_slew = 3'h3;
    localparam logic [2:0]  drive_6ma      = 3'h4;
    localparam logic [2:0]  drive_10ma     = 3'h5;
    localparam logic [2:0]  drive_12ma     = 3'h6;
    localparam logic [2:0]  pad_push_pull          = 3'h0;
    localparam logic [2:0]  pad_push_pull_pullup   = 3'h1;
    localparam logic [2:0]  pad_push_pull_pulldown = 3'h2;
    localparam logic [2:0]  pad_open_drain         = 3'h3;
    localparam logic [2:0]  pad_analog             = 3'h4;
    localparam logic [2:0]  pad_wake_high          = 3'h5;
    localparam logic [2:0]  pad_wake_low           = 3'h6;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_DIR     = 16'h0000;
    localparam logic [23:0] RST_INTTYPE = 24'h000000;
    localparam logic [23:0] RST_DRIVE   = 24'h000000;
    localparam logic [23:0] RST_PAD     = 24'h000000;
    localparam logic [31:0] RST_AFSEL   = 32'h00000000;
    localparam logic [7:0]  RST_PINSEL  = 8'hff;

    typedef enum logic [1:0] {
        LOCKED   = 2'b01,
        UNLOCKED = 2'b10
    } lock_t;
endpackage

/* verilog/gpio_port.sv */
`timescale 1ns/1ps
module gpio_port #(
    parameter bit         HAS_DISCRETE = 1'b1,
    parameter bit         HAS_WAKE     = 1'b1,
    parameter logic [7:0] PROTECT_MASK = 8'h0f
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [gpio_pkg::AW-1:0]         paddr,
    input  wire logic [31:0]                     pwdata,
    output logic [31:0]                          prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [gpio_pkg::NPIN-1:0]       pin_in,
    output logic [gpio_pkg::NPIN-1:0]            pin_out,
    output logic [gpio_pkg::NPIN-1:0]            pin_oe,
    output logic [gpio_pkg::NPIN-1:0]            pad_pullup,
    output logic [gpio_pkg::NPIN-1:0]            pad_pulldown,
    output logic [gpio_pkg::NPIN-1:0]            pad_analog_en,
    output logic [gpio_pkg::NPIN-1:0]            wake_en,
    output logic [gpio_pkg::NPIN-1:0]            wake_high,
    output logic [23:0]                          pad_drive,
    input  wire logic [gpio_pkg::NFUNC-1:0]      periph_o,
    input  wire logic [gpio_pkg::NFUNC-1:0]      periph_oe,
    input  wire logic [gpio_pkg::NFUNC-1:0]      claim_in,
    output logic [gpio_pkg::NFUNC-1:0]           claim_out,
    output logic [gpio_pkg::NFUNC-1:0]           periph_in,
    output logic [gpio_pkg::NFUNC-1:0]           periph_in_vld,
    output logic                                 irq_sum,
    output logic [gpio_pkg::NPIN-1:0]            irq_pin
);
    import gpio_pkg::*;

    logic [NPIN-1:0]  s1_r;
    logic [NPIN-1:0]  s2_r;
    logic [NPIN-1:0]  s3_r;
    logic [15:0]      dir_r;
    logic [23:0]      type_r;
    logic             disc_r;
    logic [NPIN-1:0]  en_r;
    logic [23:0]      drv_r;
    logic [23:0]      pad_r;
    logic [31:0]      af_r;
    logic [NPIN-1:0]  out_r;
    logic [NPIN-1:0]  sel_r;
    logic [NPIN-1:0]  commit_r;
    lock_t            lock_st;
    logic [NPIN-1:0]  raw;
    logic [NPIN-1:0]  masked;
    logic [NPIN-1:0]  cfg_ok;
    logic [NPIN-1:0]  clr;
    logic             setup;
    logic             wr_en;
    logic             hit_addr;
    logic [31:0]      rd_val;
    logic [NFUNC-1:0] found;
    logic [NFUNC-1:0] fval;

    // ----------------------------------------------------------------
    // Input synchroniser and previous sample
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign setup  = psel & ~penable;
    assign wr_en  = psel & penable & pwrite & pready;
    assign masked = raw & en_r;
    assign cfg_ok = sel_r & (~PROTECT_MASK | commit_r);
    assign clr    = (wr_en && paddr == OFS_RAW) ? pwdata[NPIN-1:0] : '0;
    always_comb begin
        hit_addr = 1'b1;
        rd_val   = 32'h00000000;
        if (paddr[11:10] == DATA_WIN) begin
            rd_val[NPIN-1:0] = s2_r & paddr[9:2];
        end else begin
            case (paddr)
                OFS_DIR:     rd_val[15:0] = dir_r;
                OFS_INTTYPE: rd_val = {7'h00, disc_r, type_r};
                OFS_INTEN:   rd_val[NPIN-1:0] = en_r;
                OFS_RAW:     rd_val[NPIN-1:0] = raw;
                OFS_MASKED:  rd_val[NPIN-1:0] = masked;
                OFS_DRIVE:   rd_val[23:0] = drv_r;
                OFS_PAD:     rd_val[23:0] = pad_r;
                OFS_AFSEL:   rd_val = af_r;
                OFS_LOCK:    rd_val[0] = (lock_st == LOCKED);
                OFS_COMMIT:  rd_val[NPIN-1:0] = commit_r;
                OFS_PINSEL:  rd_val[NPIN-1:0] = sel_r;
                default:     hit_addr = 1'b0;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit_addr;
            if (setup && !pwrite) begin
                prdata <= rd_val;
            end
        end
    end

    // ----------------------------------------------------------------
    // Lock and commit
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_st  <= LOCKED;
            commit_r <= '0;
        end else if (wr_en && paddr == OFS_LOCK) begin
            lock_st <= (pwdata == LOCK_KEY) ? UNLOCKED : LOCKED;
        end else if (wr_en && paddr == OFS_COMMIT) begin
            case (lock_st)
                UNLOCKED: commit_r <= pwdata[NPIN-1:0];
                default:  commit_r <= commit_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r  <= RST_DIR;
            drv_r  <= RST_DRIVE;
            pad_r  <= RST_PAD;
            af_r   <= RST_AFSEL;
            type_r <= RST_INTTYPE;
            disc_r <= 1'b0;
            en_r   <= '0;
            out_r  <= '0;
            sel_r  <= RST_PINSEL;
        end else if (wr_en) begin
            if (paddr[11:10] == DATA_WIN) begin
                out_r <= (out_r & ~paddr[9:2]) |
                         (pwdata[NPIN-1:0] & paddr[9:2]);
            end
            for (int i = 0; i < NPIN; i++) begin
                if (cfg_ok[i]) begin
                    case (paddr)
                        OFS_DIR:   dir_r[2*i +: 2] <= pwdata[2*i +: 2];
                        OFS_DRIVE: drv_r[3*i +: 3] <= pwdata[3*i +: 3];
                        OFS_PAD:   pad_r[3*i +: 3] <= pwdata[3*i +: 3];
                        OFS_AFSEL: af_r[4*i +: 4]  <= pwdata[4*i +: 4];
                        default:   ;
                    endcase
                end
                if (sel_r[i] && paddr == OFS_INTTYPE) begin
                    type_r[3*i +: 3] <= pwdata[3*i +: 3];
                end
            end
            if (paddr == OFS_INTTYPE) begin
                disc_r <= HAS_DISCRETE & pwdata[DISC_BIT];
            end
            if (paddr == OFS_INTEN) begin
                en_r <= pwdata[NPIN-1:0];
            end
            if (paddr == OFS_PINSEL) begin
                sel_r <= pwdata[NPIN-1:0];
            end
        end
    end
    // ----------------------------------------------------------------
    // Interrupt detection
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NPIN; g++) begin : g_sense
        irq_sense u_sense (
            .pclk    (pclk),
            .presetn (presetn),
            .cur     (s2_r[g]),
            .prev    (s3_r[g]),
            .sense   (type_r[3*g +: 3]),
            .clr     (clr[g]),
            .raw     (raw[g])
        );
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sum <= 1'b0;
            irq_pin <= '0;
        end else begin
            irq_sum <= (|masked) & ~disc_r;
            irq_pin <= disc_r ? masked : '0;
        end
    end
    // ----------------------------------------------------------------
    // Peripheral input routing, lowest pin then lowest port
    // ----------------------------------------------------------------
    always_comb begin
        found = '0;
        fval  = '0;
        for (int s = 0; s < NFUNC; s++) begin
            for (int i = NPIN - 1; i >= 0; i--) begin
                if (dir_r[2*i +: 2] == dir_peripheral_ctrl &&
                    af_r[4*i +: 4] == SELW'(s)) begin
                    found[s] = 1'b1;
                    fval[s]  = s2_r[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            claim_out     <= '0;
            periph_in     <= '0;
            periph_in_vld <= '0;
        end else begin
            claim_out     <= claim_in | found;
            periph_in_vld <= found & ~claim_in;
            periph_in     <= fval & ~claim_in;
        end
    end
    // ----------------------------------------------------------------
    // Pad drive
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out       <= '0;
            pin_oe        <= '0;
            pad_pullup    <= '0;
            pad_pulldown  <= '0;
            pad_analog_en <= '0;
            wake_en       <= '0;
            wake_high     <= '0;
            pad_drive     <= RST_DRIVE;
        end else begin
            pad_drive <= drv_r;
            for (int i = 0; i < NPIN; i++) begin
                logic       v;
                logic       e;
                logic [2:0] p;
                p = pad_r[3*i +: 3];
                v = out_r[i];
                e = dir_r[2*i +: 2] == DIR_OUT;
                if (dir_r[2*i +: 2] == dir_peripheral_ctrl) begin
                    v = periph_o[af_r[4*i +: 4]];
                    e = periph_oe[af_r[4*i +: 4]] &
                        ~claim_in[af_r[4*i +: 4]];
                end
                if (p == pad_analog || p == pad_wake_high ||
                    p == pad_wake_low) begin
                    e = 1'b0;
                end
                pin_out[i]       <= (p == pad_open_drain) ? 1'b0 : v;
                pin_oe[i]        <= (p == pad_open_drain) ? e & ~v : e;
                pad_pullup[i]    <= p == pad_push_pull_pullup;
                pad_pulldown[i]  <= p == pad_push_pull_pulldown;
                pad_analog_en[i] <= p == pad_analog;
                wake_en[i]       <= HAS_WAKE &&
                                    (p == pad_wake_high || p == pad_wake_low);
                wake_high[i]     <= HAS_WAKE && p == pad_wake_high;
            end
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_pin_read_value: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr[11:10] == DATA_WIN) |=>
            prdata == {24'h000000, $past(s2_r) & $past(paddr[9:2])})
        else $error("masked pin read returned wrong value");
    a_type_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == OFS_INTTYPE) |=>
            prdata[24:0] == {$past(disc_r), $past(type_r)})
        else $error("interrupt type readback mismatch");
    a_irq_gate_on: assert property (@(posedge pclk) disable iff (!presetn)
        ((|(raw & en_r)) && !disc_r) |=> irq_sum)
        else $error("enabled source did not raise summary");
    a_irq_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        ((raw & en_r) == '0) |=> (!irq_sum && irq_pin == '0))
        else $error("disabled source reached interrupt output");
    a_discrete_split: assert property (@(posedge pclk) disable iff (!presetn)
        disc_r |=> !irq_sum)
        else $error("summary fired in discrete mode");
    a_commit_locked: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_COMMIT && lock_st == LOCKED) |=> $stable(commit_r))
        else $error("commit changed while locked");
    for (genvar g = 0; g < NPIN; g++) begin : g_guard
        a_protect_dir: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && paddr == OFS_DIR && PROTECT_MASK[g] && !commit_r[g]) |=>
                $stable(dir_r[2*g +: 2]))
            else $error("protected direction changed");
    end
    a_lower_port: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (($past(claim_in) & periph_in_vld) == '0))
        else $error("claimed signal routed from higher port");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !hit_addr) |=> (pready && pslverr))
        else $error("unmapped address not flagged");

    c_summary_irq: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq_sum));
    c_discrete_irq: cover property (@(posedge pclk) disable iff (!presetn)
        irq_pin != '0);
    c_unlock_commit: cover property (@(posedge pclk) disable iff (!presetn)
        lock_st == UNLOCKED ##[1:20] commit_r != '0);
endmodule

/* verilog/irq_sense.sv */
`timescale 1ns/1ps
module irq_sense (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         cur,
    input  wire logic                         prev,
    input  wire logic [gpio_pkg::SENSE_W-1:0] sense,
    input  wire logic                         clr,
    output logic                              raw
);
    import gpio_pkg::*;

    logic hit;

    always_comb begin
        case (sense)
            SENSE_FALL: hit = prev & ~cur;
            SENSE_RISE: hit = ~prev & cur;
            SENSE_BOTH: hit = prev ^ cur;
            SENSE_LOW:  hit = ~cur;
            SENSE_HIGH: hit = cur;
            default:    hit = 1'b0;
        endcase
    end

    // Sticky flag, a new event beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw <= 1'b0;
        end else if (hit) begin
            raw <= 1'b1;
        end else if (clr) begin
            raw <= 1'b0;
        end
    end

    a_event_sets_raw: assert property (@(posedge pclk) disable iff (!presetn)
        (sense == SENSE_BOTH && prev != cur) |=> raw)
        else $error("edge did not set raw flag");
    a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (sense == SENSE_LOW && !cur) ##1 (sense == SENSE_LOW) |-> raw)
        else $error("low level did not hold raw flag");
endmodule
